// *** src/vecr_consts.svh ***
/*
 * Offsets, field positions, reset values and widths of the encoder
 * control register bank. Assumes an APB word-per-register layout.
 */
`ifndef VECR_CONSTS_SVH
`define VECR_CONSTS_SVH

// ----------------------------------------------------------------
// register indices; byte address is four times the index
// ----------------------------------------------------------------
`define VECR_IDX_SCALER_CURSOR   8'h37
`define VECR_IDX_LUMA_GAIN       8'h38
`define VECR_IDX_CDIFF_GAIN      8'h39
`define VECR_IDX_SYNC_FORMAT     8'h3a
`define VECR_IDX_PROG_SAMPLING   8'h54
`define VECR_IDX_PROG_BYTE_A     8'h55
`define VECR_IDX_PROG_BYTE_E     8'h59
`define VECR_IDX_STATUS          8'h60
`define VECR_PROG_BYTES          5

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define VECR_B_VUPSCALE          7
`define VECR_B_VFILT_HI          6
`define VECR_B_VFILT_LO          5
`define VECR_B_CURSOR_ZOOM             4
`define VECR_B_ISWING            3
`define VECR_B_HINTERP           2
`define VECR_GAIN_W              5
`define VECR_B_CBAR              7
`define VECR_B_SLVSYNC           6
`define VECR_B_TRIGSRC           5
`define VECR_B_DEMBYP            4
`define VECR_B_SYNCSEL           3
`define VECR_B_LUMAFMT           1
`define VECR_B_CHROMAFMT         0
`define VECR_B_PDINS             7
`define VECR_B_FIXVAL            5
`define VECR_B_FIXEN             4
`define VECR_B_EDGE              1
`define VECR_B_SLOT              0

// ----------------------------------------------------------------
// reset values and masks of writable bits
// ----------------------------------------------------------------
`define VECR_RST_SCALER_CURSOR   8'h00
`define VECR_RST_GAIN            8'h00
`define VECR_RST_SYNC_FORMAT     8'h03
`define VECR_RST_PROG_SAMPLING   8'h02
`define VECR_RST_PROG_BYTE       8'h00
`define VECR_MSK_SCALER_CURSOR   8'hfc
`define VECR_MSK_GAIN            8'h1f
`define VECR_MSK_SYNC_FORMAT     8'hfb
`define VECR_MSK_PROG_SAMPLING   8'hb3
`define VECR_GAIN_UNITY          6'h20
`define VECR_SIGN_FLIP           8'h80

`endif

// *** src/vecr_pkg.sv ***
/*
 * Types of the encoder control register bank.
 * Assumes the constants header is included alongside.
 */
package vecr_pkg;

	// effective vertical interpolation filter placement
	typedef enum logic [1:0] {
		VECR_VF_NONE,
		VECR_VF_BEFORE,
		VECR_VF_AFTER
	} vecr_vfilt_t;

	// program data serialiser states
	typedef enum logic [0:0] {
		VECR_PD_IDLE,
		VECR_PD_SHIFT
	} vecr_pd_state_t;

endpackage

// *** src/vecr_regs.sv ***
/*
 * Control register bank of a digital video encoder, APB slave, with
 * decode of each setting into datapath controls, sync pin muxing and
 * a serialiser for the five program data bytes of line 16.
 * Assumes one 20 MHz clock, synchronous active-high reset, and that
 * sync and line strobes from the video side arrive asynchronously.
 */
// The APB register port was decided locally.
// Function
// - vertical upscale bit resets 0; 1 enables vertical upscaling.
// - filter field 00 none (reset), 01 before, 10 after, 11 reserved.
// - vertical filter is forced off while vertical upscaling is enabled.
// - cursor zoom resets 0; set enlarges cursor two times both ways.
// - input swing bit resets 0 for 16..235; 1 expects 0..255.
// - horizontal interpolation resets 0; 1 enables filter during upscale.
// - five-bit luma gain scales luma from 1-16/32 to 1+15/32.
// - five-bit colour gain scales both colour components the same way.
// - colour bar bit 1 encodes fixed bars, 0 encodes input data.
// - slave vsync bit 0 resyncs at odd field; 1 follows vsync.
// - trigger source 0 uses sync inputs; 1 decodes embedded codes.
// - dematrix bypass resets 0 active; 1 bypasses the dematrix.
// - sync pin 0 gives pixel-clock hsync; 1 gives crystal sync_pin_select.
// - luma format 0 twos complement, 1 straight binary, resets 1.
// - chroma format 0 twos complement, 1 straight binary, resets 1.
// - program data insertion resets off; 1 inserts data in line 16.
// - monitor vsync pin carries vsync unless fixed level enable set.
// - sampling edge resets 1 normal edges; 0 samples inverse edges.
// - slot correction resets 0; 1 corrects inverted edge misalignment.
// - five program bytes are sent LSB first in line 16.
`timescale 1ns/1ps

`include "vecr_consts.svh"

module vecr_regs #(
	parameter int PD_BYTES = `VECR_PROG_BYTES
) (
	input  wire logic        clk_sys_i,
	input  wire logic        reset_i,
	// apb slave
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [11:0] paddr_i,
	input  wire logic [31:0] pwdata_i,
	input  wire logic [3:0]  pstrb_i,
	output logic      [31:0] prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	// asynchronous video-side inputs
	input  wire logic        hsync_pixel_i,
	input  wire logic        sync_pin_select_xtal_i,
	input  wire logic        vsync_monitor_i,
	input  wire logic        line16_start_i,
	input  wire logic        pd_bit_tick_i,
	input  wire logic [7:0]  pixel_luma_i,
	input  wire logic [7:0]  pixel_chroma_i,
	// decoded controls
	output logic             vertical_upscale_enable_o,
	output vecr_pkg::vecr_vfilt_t vertical_filter_o,
	output logic             cursor_zoom_o,
	output logic             input_swing_select_o,
	output logic             horizontal_interp_enable_o,
	output logic      [5:0]  luma_gain_factor_o,
	output logic      [5:0]  chroma_gain_factor_o,
	output logic             colour_bar_enable_o,
	output logic             slave_vertical_sync_mode_o,
	output logic             trigger_source_select_o,
	output logic             dematrix_bypass_o,
	output logic             sampling_edge_o,
	output logic             slot_correction_o,
	output logic      [7:0]  luma_binary_o,
	output logic      [7:0]  chroma_binary_o,
	output logic             horizontal_sync_out_pin_o,
	output logic             monitor_vsync_pin_o,
	output logic             program_data_bit_o,
	output logic             program_data_valid_o
);

	// ----------------------------------------------------------------
	// register storage
	// ----------------------------------------------------------------
	logic [7:0] scaler_cursor_input_control_q;
	logic [7:0] output_luma_gain_q;
	logic [7:0] output_colour_diff_gain_q;
	logic [7:0] sync_format_control_q;
	logic [7:0] program_data_and_sampling_control_q;
	logic [7:0] program_data_byte_q [PD_BYTES];

	logic [7:0]  idx;
	logic        addr_ok;
	logic        wr_en;
	logic        setup;
	logic        pd_busy_q;

	// word aligned, low byte lane only carries data
	assign idx   = paddr_i[9:2];
	assign setup = psel_i & ~penable_i;
	assign wr_en = psel_i & penable_i & pwrite_i & pstrb_i[0] & addr_ok;

	// address decode
	always_comb begin
		addr_ok = (paddr_i[1:0] == 2'h0) && (paddr_i[11:10] == 2'h0) &&
			((idx >= `VECR_IDX_SCALER_CURSOR &&
			  idx <= `VECR_IDX_SYNC_FORMAT) ||
			 (idx >= `VECR_IDX_PROG_SAMPLING &&
			  idx <= `VECR_IDX_PROG_BYTE_E) ||
			 idx == `VECR_IDX_STATUS);
	end

	// control registers hold the last write until reset
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			scaler_cursor_input_control_q       <= `VECR_RST_SCALER_CURSOR;
			output_luma_gain_q                  <= `VECR_RST_GAIN;
			output_colour_diff_gain_q           <= `VECR_RST_GAIN;
			sync_format_control_q               <= `VECR_RST_SYNC_FORMAT;
			program_data_and_sampling_control_q <= `VECR_RST_PROG_SAMPLING;
		end else if (wr_en) begin
			unique case (idx)
				`VECR_IDX_SCALER_CURSOR: begin
					scaler_cursor_input_control_q <=
						pwdata_i[7:0] & `VECR_MSK_SCALER_CURSOR;
				end
				`VECR_IDX_LUMA_GAIN: begin
					output_luma_gain_q <= pwdata_i[7:0] & `VECR_MSK_GAIN;
				end
				`VECR_IDX_CDIFF_GAIN: begin
					output_colour_diff_gain_q <=
						pwdata_i[7:0] & `VECR_MSK_GAIN;
				end
				`VECR_IDX_SYNC_FORMAT: begin
					sync_format_control_q <=
						pwdata_i[7:0] & `VECR_MSK_SYNC_FORMAT;
				end
				`VECR_IDX_PROG_SAMPLING: begin
					program_data_and_sampling_control_q <=
						pwdata_i[7:0] & `VECR_MSK_PROG_SAMPLING;
				end
				default: begin
				end
			endcase
		end
	end

	// program data bytes, one per index
	genvar gi;
	generate
		for (gi = 0; gi < PD_BYTES; gi++) begin : g_pdb
			always_ff @(posedge clk_sys_i) begin
				if (reset_i) begin
					program_data_byte_q[gi] <= `VECR_RST_PROG_BYTE;
				end else if (wr_en &&
					idx == `VECR_IDX_PROG_BYTE_A + 8'(gi)) begin
					program_data_byte_q[gi] <= pwdata_i[7:0];
				end
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// apb read path: data captured in setup, shown in access
	// ----------------------------------------------------------------
	logic [7:0] rd_byte;
	logic       err_q;
	logic [7:0] pd_rd;

	always_comb begin
		pd_rd = 8'h00;
		for (int i = 0; i < PD_BYTES; i++) begin
			if (idx == `VECR_IDX_PROG_BYTE_A + 8'(i)) begin
				pd_rd = program_data_byte_q[i];
			end
		end
	end

	always_comb begin
		rd_byte = 8'h00;
		unique case (idx)
			`VECR_IDX_SCALER_CURSOR: rd_byte = scaler_cursor_input_control_q;
			`VECR_IDX_LUMA_GAIN:     rd_byte = output_luma_gain_q;
			`VECR_IDX_CDIFF_GAIN:    rd_byte = output_colour_diff_gain_q;
			`VECR_IDX_SYNC_FORMAT:   rd_byte = sync_format_control_q;
			`VECR_IDX_PROG_SAMPLING: begin
				rd_byte = program_data_and_sampling_control_q;
			end
			`VECR_IDX_STATUS: begin
				rd_byte = {6'h00, vertical_filter_o == vecr_pkg::VECR_VF_NONE,
					pd_busy_q};
			end
			default: rd_byte = pd_rd;
		endcase
	end

	// registered read data avoids a long decode path onto the bus
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			prdata_o <= 32'h0000_0000;
			err_q    <= 1'b0;
		end else if (setup) begin
			prdata_o <= (addr_ok && !pwrite_i) ? {24'h00_0000, rd_byte}
				: 32'h0000_0000;
			err_q    <= ~addr_ok;
		end
	end

	assign pready_o  = 1'b1;
	assign pslverr_o = psel_i & penable_i & err_q;

	// ----------------------------------------------------------------
	// decode of settings
	// ----------------------------------------------------------------
	logic [1:0] vf_sel;
	assign vf_sel = scaler_cursor_input_control_q[`VECR_B_VFILT_HI:
		`VECR_B_VFILT_LO];

	// reserved code behaves as no filter, a safe fallback
	always_comb begin
		vertical_filter_o = vecr_pkg::VECR_VF_NONE;
		if (!vertical_upscale_enable_o) begin
			unique case (vf_sel)
				2'h1:    vertical_filter_o = vecr_pkg::VECR_VF_BEFORE;
				2'h2:    vertical_filter_o = vecr_pkg::VECR_VF_AFTER;
				default: vertical_filter_o = vecr_pkg::VECR_VF_NONE;
			endcase
		end
	end

	assign vertical_upscale_enable_o  =
		scaler_cursor_input_control_q[`VECR_B_VUPSCALE];
	assign cursor_zoom_o              =
		scaler_cursor_input_control_q[`VECR_B_CURSOR_ZOOM];
	assign input_swing_select_o       =
		scaler_cursor_input_control_q[`VECR_B_ISWING];
	assign horizontal_interp_enable_o =
		scaler_cursor_input_control_q[`VECR_B_HINTERP];

	// gain factor in 32nds: 32 plus signed field, 16..47
	assign luma_gain_factor_o = `VECR_GAIN_UNITY +
		{{1{output_luma_gain_q[4]}}, output_luma_gain_q[4:0]};
	assign chroma_gain_factor_o = `VECR_GAIN_UNITY +
		{{1{output_colour_diff_gain_q[4]}}, output_colour_diff_gain_q[4:0]};

	assign colour_bar_enable_o        =
		sync_format_control_q[`VECR_B_CBAR];
	assign slave_vertical_sync_mode_o =
		sync_format_control_q[`VECR_B_SLVSYNC];
	assign trigger_source_select_o    =
		sync_format_control_q[`VECR_B_TRIGSRC];
	assign dematrix_bypass_o          =
		sync_format_control_q[`VECR_B_DEMBYP];
	assign sampling_edge_o            =
		program_data_and_sampling_control_q[`VECR_B_EDGE];
	assign slot_correction_o          =
		program_data_and_sampling_control_q[`VECR_B_SLOT];

	// number format: twos complement flips the sign bit to binary
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			luma_binary_o   <= 8'h00;
			chroma_binary_o <= 8'h00;
		end else begin
			luma_binary_o   <= sync_format_control_q[`VECR_B_LUMAFMT] ?
				pixel_luma_i : pixel_luma_i ^ `VECR_SIGN_FLIP;
			chroma_binary_o <= sync_format_control_q[`VECR_B_CHROMAFMT] ?
				pixel_chroma_i : pixel_chroma_i ^ `VECR_SIGN_FLIP;
		end
	end

	// ----------------------------------------------------------------
	// synchronisers for asynchronous video-side levels
	// ----------------------------------------------------------------
	logic [4:0] sync_m_q;
	logic [4:0] sync_s_q;
	logic       line16_prev_q;
	logic       tick_prev_q;

	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			sync_m_q <= 5'h00;
			sync_s_q <= 5'h00;
		end else begin
			sync_m_q <= {pd_bit_tick_i, line16_start_i, vsync_monitor_i,
				sync_pin_select_xtal_i, hsync_pixel_i};
			sync_s_q <= sync_m_q;
		end
	end

	// sync pins: registered mux of the synchronised sources
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			horizontal_sync_out_pin_o <= 1'b0;
			monitor_vsync_pin_o       <= 1'b0;
		end else begin
			horizontal_sync_out_pin_o <=
				sync_format_control_q[`VECR_B_SYNCSEL] ?
				sync_s_q[1] : sync_s_q[0];
			monitor_vsync_pin_o <=
				program_data_and_sampling_control_q[`VECR_B_FIXEN] ?
				program_data_and_sampling_control_q[`VECR_B_FIXVAL] :
				sync_s_q[2];
		end
	end

	// ----------------------------------------------------------------
	// program data serialiser, line 16
	// ----------------------------------------------------------------
	localparam int PD_BITS = PD_BYTES * 8;
	vecr_pkg::vecr_pd_state_t pd_state_q;
	logic [PD_BITS-1:0]       pd_shift_q;
	logic [7:0]               pd_count_q;
	logic                     line16_rise;
	logic                     tick_rise;
	logic [PD_BITS-1:0]       pd_load;

	assign line16_rise = sync_s_q[3] & ~line16_prev_q;
	assign tick_rise   = sync_s_q[4] & ~tick_prev_q;

	// byte a sits lowest so it leaves first, each byte lsb first
	always_comb begin
		pd_load = '0;
		for (int i = 0; i < PD_BYTES; i++) begin
			pd_load[i*8 +: 8] = program_data_byte_q[i];
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			line16_prev_q <= 1'b0;
			tick_prev_q   <= 1'b0;
		end else begin
			line16_prev_q <= sync_s_q[3];
			tick_prev_q   <= sync_s_q[4];
		end
	end

	// a line start while disabled is ignored; mid-burst starts too
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			pd_state_q <= vecr_pkg::VECR_PD_IDLE;
			pd_shift_q <= '0;
			pd_count_q <= 8'h00;
		end else begin
			unique case (pd_state_q)
				vecr_pkg::VECR_PD_IDLE: begin
					if (line16_rise &&
						program_data_and_sampling_control_q[`VECR_B_PDINS]) begin
						pd_state_q <= vecr_pkg::VECR_PD_SHIFT;
						pd_shift_q <= pd_load;
						pd_count_q <= 8'h00;
					end
				end
				vecr_pkg::VECR_PD_SHIFT: begin
					if (tick_rise) begin
						pd_shift_q <= pd_shift_q >> 1;
						pd_count_q <= pd_count_q + 8'h01;
						if (pd_count_q == 8'(PD_BITS - 1)) begin
							pd_state_q <= vecr_pkg::VECR_PD_IDLE;
						end
					end
				end
			endcase
		end
	end

	// serial output from flops, advanced on each bit tick
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			program_data_bit_o   <= 1'b0;
			program_data_valid_o <= 1'b0;
			pd_busy_q            <= 1'b0;
		end else begin
			program_data_bit_o   <= pd_shift_q[0];
			program_data_valid_o <= (pd_state_q == vecr_pkg::VECR_PD_SHIFT) &
				tick_rise;
			pd_busy_q <= (pd_state_q == vecr_pkg::VECR_PD_SHIFT);
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (reset_i);

	chk_vf_off_upscale: assert property (
		vertical_upscale_enable_o |-> vertical_filter_o == vecr_pkg::VECR_VF_NONE)
		else $error("vertical filter active during upscaling");

	chk_vf_decode_map: assert property (
		!vertical_upscale_enable_o && vf_sel == 2'h2 |->
		vertical_filter_o == vecr_pkg::VECR_VF_AFTER)
		else $error("vertical filter after-scaling decode wrong");

	chk_gain_range: assert property (
		luma_gain_factor_o >= 6'd16 && luma_gain_factor_o <= 6'd47)
		else $error("luma gain factor out of range");

	chk_gain_nominal: assert property (
		output_luma_gain_q == 8'h00 |-> luma_gain_factor_o == 6'd32)
		else $error("luma gain not unity at zero");

	chk_cgain_track: assert property (
		output_colour_diff_gain_q == 8'h10 |-> chroma_gain_factor_o == 6'd16)
		else $error("colour gain minimum wrong");

	chk_write_holds: assert property (
		wr_en && idx == `VECR_IDX_LUMA_GAIN |=>
		output_luma_gain_q == ($past(pwdata_i[7:0]) & `VECR_MSK_GAIN))
		else $error("written gain not stored");

	chk_reg_stable: assert property (
		!wr_en |=> $stable(sync_format_control_q))
		else $error("register changed without write");

	chk_vsm_fixed: assert property (
		program_data_and_sampling_control_q[`VECR_B_FIXEN] ##1
		program_data_and_sampling_control_q[`VECR_B_FIXEN] |->
		monitor_vsync_pin_o ==
		$past(program_data_and_sampling_control_q[`VECR_B_FIXVAL]))
		else $error("monitor vsync pin not at fixed level");

	chk_hsync_sel: assert property (
		!$past(sync_format_control_q[`VECR_B_SYNCSEL]) |->
		horizontal_sync_out_pin_o == $past(sync_s_q[0]))
		else $error("hsync pin not from pixel clock sync");

	chk_pd_disabled: assert property (
		line16_rise && !program_data_and_sampling_control_q[`VECR_B_PDINS] &&
		pd_state_q == vecr_pkg::VECR_PD_IDLE |=>
		pd_state_q == vecr_pkg::VECR_PD_IDLE)
		else $error("program data sent while disabled");

	chk_pd_first_bit: assert property (
		pd_state_q == vecr_pkg::VECR_PD_IDLE ##1
		pd_state_q == vecr_pkg::VECR_PD_SHIFT |->
		pd_shift_q[0] == program_data_byte_q[0][0])
		else $error("first program bit not lsb of first byte");

	chk_luma_fmt: assert property (
		!sync_format_control_q[`VECR_B_LUMAFMT] |=>
		luma_binary_o == ($past(pixel_luma_i) ^ `VECR_SIGN_FLIP))
		else $error("twos complement luma not converted");

	chk_apb_err: assert property (
		setup && !addr_ok |=> pslverr_o || !(psel_i && penable_i))
		else $error("unmapped access not flagged");

endmodule

// *** test/vecr_host.sv ***
/*
 * APB host model that sets up the encoder control register bank.
 * Assumes one clock and a slave that answers through pready.
 */
`timescale 1ns/1ps

module vecr_host (
	input  wire logic        clk_i,
	input  wire logic        pready_i,
	output logic             psel_o,
	output logic             penable_o,
	output logic             pwrite_o,
	output logic      [11:0] paddr_o,
	output logic      [31:0] pwdata_o,
	output logic      [3:0]  pstrb_o,
	output logic             hung_o
);
	// ------------------------------------------------------------
	// bus idle state
	// ------------------------------------------------------------
	initial begin
		psel_o = 1'b0;
		penable_o = 1'b0;
		pwrite_o = 1'b0;
		paddr_o = 12'h000;
		pwdata_o = 32'h00000000;
		pstrb_o = 4'h0;
		hung_o = 1'b0;
	end

	// ------------------------------------------------------------
	// one transfer; starts at the next edge so calls never collide
	// ------------------------------------------------------------
	task automatic xfer(input logic wr, input logic [11:0] a,
		input logic [31:0] d, input logic [3:0] s);
		int n;
		@(posedge clk_i);
		psel_o <= 1'b1;
		pwrite_o <= wr;
		paddr_o <= a;
		pwdata_o <= d;
		pstrb_o <= s;
		@(posedge clk_i);
		penable_o <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (pready_i !== 1'b1 && n < 64);
		hung_o <= (n >= 64);
		psel_o <= 1'b0;
		penable_o <= 1'b0;
		// released lines show garbage, not the last value
		paddr_o <= ~a;
		pwdata_o <= ~d;
	endtask

endmodule

// *** test/video_encoder_control_regs_test.sv ***
/*
 * Self-checking bench of the encoder control register bank.
 * Assumes the host model drives APB and this module the video side.
 */
`timescale 1ns/1ps
`include "vecr_consts.svh"

module video_encoder_control_regs_test;
	logic        clk_sys_i = 1'b0;
	logic        reset_i = 1'b1;
	logic        psel, penable, pwrite, pready, pslverr, hung;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic [3:0]  pstrb;
	logic        hs = 0, cs = 0, vs = 0, l16 = 0, tick = 0;
	logic [7:0]  lu = 0, ch = 0, v, pd[5];
	logic        up, zm, sw, hi, cb, sv, tr, db, ed, sl, hp, vp, pb, pv;
	logic [5:0]  lg, cg;
	logic [7:0]  lb, cbin;
	vecr_pkg::vecr_vfilt_t vf;
	logic [32:0] rq[$];
	logic        bq[$];
	int          mismatches = 0;
	int          compares = 0;
	logic [7:0]  idx[10] = '{8'h37, 8'h38, 8'h39, 8'h3a, 8'h54,
		8'h55, 8'h56, 8'h57, 8'h58, 8'h59};
	logic [7:0]  rst[10] = '{8'h00, 8'h00, 8'h00, 8'h03, 8'h02,
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
	logic [7:0]  msk[10] = '{8'hfc, 8'h1f, 8'h1f, 8'hfb, 8'hb3,
		8'hff, 8'hff, 8'hff, 8'hff, 8'hff};
	logic [4:0]  gt[4] = '{5'h10, 5'h0f, 5'h00, 5'h1f};

	always #25 clk_sys_i = ~clk_sys_i;

	vecr_host vecr_host_i (.clk_i(clk_sys_i), .pready_i(pready),
		.psel_o(psel), .penable_o(penable), .pwrite_o(pwrite),
		.paddr_o(paddr), .pwdata_o(pwdata), .pstrb_o(pstrb),
		.hung_o(hung));

	vecr_regs vecr_regs_i (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
		.psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
		.paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb),
		.prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
		.hsync_pixel_i(hs), .sync_pin_select_xtal_i(cs), .vsync_monitor_i(vs),
		.line16_start_i(l16), .pd_bit_tick_i(tick),
		.pixel_luma_i(lu), .pixel_chroma_i(ch),
		.vertical_upscale_enable_o(up), .vertical_filter_o(vf),
		.cursor_zoom_o(zm), .input_swing_select_o(sw),
		.horizontal_interp_enable_o(hi), .luma_gain_factor_o(lg),
		.chroma_gain_factor_o(cg), .colour_bar_enable_o(cb),
		.slave_vertical_sync_mode_o(sv),
		.trigger_source_select_o(tr), .dematrix_bypass_o(db),
		.sampling_edge_o(ed), .slot_correction_o(sl),
		.luma_binary_o(lb), .chroma_binary_o(cbin),
		.horizontal_sync_out_pin_o(hp), .monitor_vsync_pin_o(vp),
		.program_data_bit_o(pb), .program_data_valid_o(pv));

	// ------------------------------------------------------------
	// comparison, verdict and bus helpers
	// ------------------------------------------------------------
	task automatic check(input logic [32:0] seen, input logic [32:0] exp);
		compares++;
		if (seen !== exp) begin
			mismatches++;
			$display("[ERR] %0t got %h want %h", $time, seen, exp);
		end
	endtask

	task automatic stop_test;
		if (mismatches == 0 && compares > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic wr(input logic [7:0] i, input logic [31:0] d);
		vecr_host_i.xfer(1'b1, {2'b00, i, 2'b00}, d, 4'h1);
	endtask

	task automatic rd(input logic [11:0] a, input logic [32:0] e);
		rq.push_back(e);
		vecr_host_i.xfer(1'b0, a, 32'h00000000, 4'h0);
	endtask

	// line start then 40 slow ticks; the synchronisers need wide pulses
	task automatic burst;
		l16 <= 1'b1;
		repeat (4) @(posedge clk_sys_i);
		l16 <= 1'b0;
		repeat (40) begin
			repeat (4) @(posedge clk_sys_i);
			tick <= 1'b1;
			repeat (4) @(posedge clk_sys_i);
			tick <= 1'b0;
		end
		repeat (8) @(posedge clk_sys_i);
	endtask

	// ------------------------------------------------------------
	// output watcher: read data and serial bits against the notes
	// ------------------------------------------------------------
	always @(negedge clk_sys_i) begin
		if (psel && penable && pready === 1'b1 && !pwrite) begin
			check({pslverr, prdata}, rq.pop_front());
		end
		if (pv === 1'b1) begin
			check(pb, bq.size() ? bq.pop_front() : 1'bx);
		end
	end

	// a stuck transfer ends the run
	always @(posedge hung) begin
		mismatches++;
		stop_test;
	end

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		void'($urandom(32'h5d642593));
		repeat (4) @(posedge clk_sys_i);
		reset_i <= 1'b0;
		for (int i = 0; i < 10; i++) rd({2'b00, idx[i], 2'b00}, rst[i]);
		rd(12'h180, 33'h0_0000_0002);
		check(lg, 6'h20);
		check(ed, 1'b1);
		// random fill, masked write, then refused accesses
		for (int i = 0; i < 10; i++) begin
			r = $urandom;
			wr(idx[i], r);
			vecr_host_i.xfer(1'b1, {2'b00, idx[i], 2'b00}, ~r, 4'h0);
			rd({2'b00, idx[i], 2'b00}, r[7:0] & msk[i]);
			if (i >= 5) pd[i - 5] = r[7:0];
		end
		rd(12'h100, {1'b1, 32'h0});
		rd(12'h0dd, {1'b1, 32'h0});
		// every upscale and filter code
		for (int k = 0; k < 8; k++) begin
			r = $urandom;
			v = {k[2:0], r[4:0]};
			wr(8'h37, v);
			@(negedge clk_sys_i);
			check(up, v[7]);
			check(vf, (v[7] || v[6:5] == 2'b11) ? 2'b00 : v[6:5]);
			check(zm, v[4]);
			check(sw, v[3]);
			check(hi, v[2]);
		end
		// gain boundaries and one random value
		for (int k = 0; k < 5; k++) begin
			r = $urandom;
			if (k < 4) r[4:0] = gt[k];
			wr(8'h38, r);
			wr(8'h39, ~r);
			@(negedge clk_sys_i);
			check(lg, 6'(6'h20 + {r[4], r[4:0]}));
			check(cg, 6'(6'h20 + {~r[4], ~r[4:0]}));
		end
		// sync and format settings with live video inputs
		for (int k = 0; k < 4; k++) begin
			r = $urandom;
			wr(8'h3a, r);
			hs <= r[9];
			cs <= r[10];
			lu <= r[23:16];
			ch <= r[31:24];
			repeat (5) @(negedge clk_sys_i);
			check(cb, r[7]);
			check(sv, r[6]);
			check(tr, r[5]);
			check(db, r[4]);
			check(hp, r[3] ? r[10] : r[9]);
			check(lb, r[1] ? r[23:16] : r[23:16] ^ 8'h80);
			check(cbin, r[0] ? r[31:24] : r[31:24] ^ 8'h80);
		end
		for (int k = 0; k < 4; k++) begin
			r = $urandom;
			wr(8'h54, {1'b0, r[6], k[1:0], r[3:0]});
			vs <= r[8];
			repeat (5) @(negedge clk_sys_i);
			check(vp, k[0] ? k[1] : r[8]);
			check(ed, r[1]);
			check(sl, r[0]);
		end
		// insertion off: nothing may come out; then on: all 40 bits in order
		burst;
		wr(8'h54, 32'h00000080);
		for (int n = 0; n < 40; n++) bq.push_back(pd[n / 8][n % 8]);
		burst;
		check(bq.size(), 0);
		check(rq.size(), 0);
		stop_test;
	end

endmodule
